// File: positioner_map.vh
// Offsets, fields, reset values and timing counts of the positioner mode control.
// Contract
// - Home sensor polarity 0 means no sensor, 1 means normally-open sensor.
// - Home sensor polarity 2 treats the sensor as normally-closed.
// - Homing drives to mechanical end, samples sensor, reverses, stops at home.
// - Homing succeeds only if sensor level changed; else error and alarm. With polarity 0 the code reports success without this check.
// - Load output on once torque-over time reaches judgment time, default 255 ms.
// - Torque range setting 0 uses the check range, 1 ignores it; default 0.
// - Axis kind 0 is linear, 1 is rotational.
// - Rotational index mode wraps position into 0 to 359.99; 0 is normal mode.
// - Shortest-path motion is allowed only on a rotational axis in index mode.
// - Index mode ignores push data, moves normally, uses default positioning band.
// - Shortest-path setting 1 takes the shorter direction; 0 disables it.
// - On a rotational axis one position unit is one degree, like 1 mm.
// - Absolute unit setting 0 means unit absent, 1 means present.
// - I/O pattern defaults to 0 and governs how parallel I/O is read.
// - Pattern 0 has 64 points and two zones, parameter and table bounds.
// - Pattern 1 has 64 points, one table zone, teaching mode and jog.
// - Pattern 2 has 256 points and one table-bound zone output.
// - Pattern 3 has 512 points and no zone output.
// - Pattern 4 has seven points, each with direct start and complete output.
// - Pattern 5 has three points, no push, completes act as position detectors.
// - Level start moves while the input is on; dropping it decelerates to stop.
// - Edge start moves on a rising edge and continues if the input drops.
`ifndef POSITIONER_MAP_VH
`define POSITIONER_MAP_VH
`define ADDR_CONFIG      4'h0
`define ADDR_LOAD_TIME   4'h1
`define ADDR_STATUS      4'h2
`define ADDR_POSITION    4'h3
`define ADDR_COMMAND     4'h4
`define CFG_HOME_POL_LO  0
`define CFG_TRQ_RANGE    2
`define CFG_AXIS_KIND    3
`define CFG_INDEX_MODE   4
`define CFG_SHORTCUT     5
`define CFG_ABS_UNIT     6
`define CFG_PATTERN_LO   8
`define CFG_START_EDGE   11
`define CONFIG_RESET     32'h0000_0000
`define LOAD_TIME_RESET  16'h00ff
`define HOME_POL_NONE    2'h0
`define HOME_POL_NO      2'h1
`define HOME_POL_NC      2'h2
`define FULL_TURN        32'h0000_8ca0
`define HALF_TURN        32'h0000_4650
`define TICK_MS          1
`define CLK_MHZ          250
`define TICK_CYCLES      (`TICK_MS * `CLK_MHZ * 1000)
`endif

// File: positioner_pio_mode_control.v
// Mode, homing, load judgment and parallel I/O pattern control of the positioner.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`include "positioner_map.vh"
module positioner_pio_mode_control #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter NUM_DIRECT  = 7
) (
  input  wire                   clk,
  input  wire                   rst,
  input  wire [3:0]             avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  output reg  [31:0]            avs_readdata,
  output reg                    avs_waitrequest,
  input  wire                   home_sensor_pin,
  input  wire                   mech_end_hit,
  input  wire                   home_pos_hit,
  output reg                    home_drive_run,
  output reg                    home_drive_reverse,
  output reg                    home_done,
  output reg                    home_error,
  output reg                    alarm_out,
  input  wire                   push_active,
  input  wire                   torque_over,
  input  wire                   torque_in_range,
  output reg                    load_out,
  input  wire signed [31:0]     raw_position,
  input  wire signed [31:0]     target_position,
  output reg  signed [31:0]     shown_position,
  output reg                    move_reverse,
  output reg                    push_permitted,
  output reg                    default_band_sel,
  output reg  [9:0]             point_count,
  output reg  [1:0]             zone_count,
  output reg                    zone_param_used,
  output reg                    teach_jog_allowed,
  input  wire [NUM_DIRECT-1:0]  direct_move_inputs,
  input  wire                   move_finished,
  input  wire [NUM_DIRECT-1:0]  point_in_band,
  output reg                    move_start,
  output reg  [2:0]             move_point,
  output reg                    move_decel_stop,
  output reg  [NUM_DIRECT-1:0]  move_complete
);

  localparam H_IDLE    = 3'h0;
  localparam H_TO_END  = 3'h1;
  localparam H_REVERSE = 3'h2;
  localparam H_CHECK   = 3'h3;

  reg  [31:0]           config_reg;
  reg  [15:0]           load_time_reg;
  reg  [2:0]            home_state_reg;
  reg                   home_sync1_reg;
  reg                   home_sync2_reg;
  reg                   home_at_end_reg;
  reg  [31:0]           tick_cnt_reg;
  reg                   tick_reg;
  reg  [15:0]           load_acc_reg;
  reg  [NUM_DIRECT-1:0] st_sync1_reg;
  reg  [NUM_DIRECT-1:0] st_sync2_reg;
  reg  [NUM_DIRECT-1:0] st_prev_reg;
  reg                   moving_reg;
  reg  [2:0]            active_point_reg;
  reg                   home_start_reg;
  reg  [NUM_DIRECT-1:0] held_reg;

  wire [1:0] home_pol   = config_reg[`CFG_HOME_POL_LO+1:`CFG_HOME_POL_LO];
  wire       trq_range  = config_reg[`CFG_TRQ_RANGE];
  wire       rotary     = config_reg[`CFG_AXIS_KIND];
  wire       index_mode = rotary & config_reg[`CFG_INDEX_MODE];
  wire       shortcut   = config_reg[`CFG_SHORTCUT];
  wire       abs_unit   = config_reg[`CFG_ABS_UNIT];
  wire [2:0] pattern    = config_reg[`CFG_PATTERN_LO+2:`CFG_PATTERN_LO];
  wire       edge_start = config_reg[`CFG_START_EDGE];
  wire       bus_req    = avs_read | avs_write;
  wire       bus_take   = bus_req & ~avs_waitrequest;

  // Positions are in hundredths of a unit; on a rotational axis one unit is one degree.
  // degree per unit
  function [31:0] wrap_turn;
    input signed [31:0] p;
    reg signed [31:0] m;
    begin
      m = p % $signed(`FULL_TURN);
      if (m < 0) begin
        m = m + $signed(`FULL_TURN);
      end
      wrap_turn = m;
    end
  endfunction

  // Sensor reads as detected according to its fitted contact type.
  function sensor_active;
    input [1:0] pol;
    input       lvl;
    begin
      case (pol)
        `HOME_POL_NO: sensor_active = lvl;
        `HOME_POL_NC: sensor_active = ~lvl;
        default:      sensor_active = 1'b0;
      endcase
    end
  endfunction

  function [2:0] lowest_set;
    input [NUM_DIRECT-1:0] v;
    integer i;
    begin
      lowest_set = 3'h0;
      for (i = NUM_DIRECT - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          lowest_set = i[2:0];
        end
      end
    end
  endfunction

  // Avalon slave: one wait state, then waitrequest low for exactly one cycle.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest & avs_read) begin
        case (avs_address)
          `ADDR_CONFIG:    avs_readdata <= config_reg;
          `ADDR_LOAD_TIME: avs_readdata <= {16'h0000, load_time_reg};
          `ADDR_STATUS:    avs_readdata <= {24'h000000, abs_unit, moving_reg, load_out,
                                            sensor_active(home_pol, home_sync2_reg),
                                            alarm_out, home_error, home_done, home_drive_run};
          `ADDR_POSITION:  avs_readdata <= shown_position;
          default:         avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Setup registers; the I/O pattern resets to 0 and software sets it before anything else.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      config_reg     <= `CONFIG_RESET;
      load_time_reg  <= `LOAD_TIME_RESET;
      home_start_reg <= 1'b0;
    end else begin
      home_start_reg <= 1'b0;
      if (bus_take & avs_write) begin
        case (avs_address)
          `ADDR_CONFIG:    config_reg <= avs_writedata & 32'h0000_0f7f;
          `ADDR_LOAD_TIME: load_time_reg <= avs_writedata[15:0];
          `ADDR_COMMAND:   home_start_reg <= avs_writedata[0];
          default:         config_reg <= config_reg;
        endcase
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      home_sync1_reg <= 1'b0;
      home_sync2_reg <= 1'b0;
      st_sync1_reg   <= {NUM_DIRECT{1'b0}};
      st_sync2_reg   <= {NUM_DIRECT{1'b0}};
      st_prev_reg    <= {NUM_DIRECT{1'b0}};
    end else begin
      home_sync1_reg <= home_sensor_pin;
      home_sync2_reg <= home_sync1_reg;
      st_sync1_reg   <= direct_move_inputs;
      st_sync2_reg   <= st_sync1_reg;
      st_prev_reg    <= st_sync2_reg;
    end
  end

  // Homing sequence and sensor verification.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      home_state_reg     <= H_IDLE;
      home_at_end_reg    <= 1'b0;
      home_drive_run     <= 1'b0;
      home_drive_reverse <= 1'b0;
      home_done          <= 1'b0;
      home_error         <= 1'b0;
      alarm_out          <= 1'b0;
    end else begin
      case (home_state_reg)
        H_IDLE: begin
          if (home_start_reg) begin
            home_done      <= 1'b0;
            home_error     <= 1'b0;
            alarm_out      <= 1'b0;
            home_drive_run <= 1'b1;
            home_state_reg <= H_TO_END;
          end
        end
        H_TO_END: begin
          if (mech_end_hit) begin
            home_at_end_reg    <= home_sync2_reg;
            home_drive_reverse <= 1'b1;
            home_state_reg     <= H_REVERSE;
          end
        end
        H_REVERSE: begin
          if (home_pos_hit) begin
            home_drive_run     <= 1'b0;
            home_drive_reverse <= 1'b0;
            home_state_reg     <= H_CHECK;
          end
        end
        H_CHECK: begin
          home_state_reg <= H_IDLE;
          if (home_pol == `HOME_POL_NONE) begin
            home_done <= 1'b1;
          end else if (home_sync2_reg != home_at_end_reg) begin
            home_done <= 1'b1;
          end else begin
            home_error <= 1'b1;
            alarm_out  <= 1'b1;
          end
        end
        default: begin
          home_state_reg <= H_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (tick_cnt_reg >= TICK_CYCLES - 1) begin
        tick_cnt_reg <= 32'h0000_0000;
        tick_reg     <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Load judgment sums the milliseconds spent over threshold inside the check range, or all of them when the range is ignored; it restarts with each push.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      load_acc_reg <= 16'h0000;
      load_out     <= 1'b0;
    end else if (~push_active | ~push_permitted) begin
      load_acc_reg <= 16'h0000;
      load_out     <= 1'b0;
    end else begin
      if (tick_reg & torque_over & (trq_range | torque_in_range) & (load_acc_reg != 16'hffff)) begin
        load_acc_reg <= load_acc_reg + 16'h0001;
      end
      if (load_acc_reg >= load_time_reg) begin
        load_out <= 1'b1;
      end
    end
  end

  // Axis handling and pattern decode.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shown_position    <= 32'sh0000_0000;
      move_reverse      <= 1'b0;
      push_permitted    <= 1'b1;
      default_band_sel  <= 1'b0;
      point_count       <= 10'h040;
      zone_count        <= 2'h2;
      zone_param_used   <= 1'b1;
      teach_jog_allowed <= 1'b0;
    end else begin
      shown_position <= index_mode ? $signed(wrap_turn(raw_position)) : raw_position;
      if (index_mode & shortcut) begin
        move_reverse <= wrap_turn(target_position - raw_position) > `HALF_TURN;
      end else begin
        move_reverse <= target_position < raw_position;
      end
      push_permitted   <= ~index_mode & (pattern != 3'h5);
      default_band_sel <= index_mode;
      teach_jog_allowed <= 1'b0;
      zone_param_used   <= 1'b0;
      case (pattern)
        3'h0: begin
          point_count     <= 10'h040;
          zone_count      <= 2'h2;
          zone_param_used <= 1'b1;
        end
        3'h1: begin
          point_count       <= 10'h040;
          zone_count        <= 2'h1;
          teach_jog_allowed <= 1'b1;
        end
        3'h2: begin
          point_count <= 10'h100;
          zone_count  <= 2'h1;
        end
        3'h3: begin
          point_count <= 10'h200;
          zone_count  <= 2'h0;
        end
        3'h4: begin
          point_count <= 10'h007;
          zone_count  <= 2'h0;
        end
        3'h5: begin
          point_count <= 10'h003;
          zone_count  <= 2'h0;
        end
        default: begin
          point_count <= 10'h000;
          zone_count  <= 2'h0;
        end
      endcase
    end
  end

  wire       direct_mode = (pattern == 3'h4) | (pattern == 3'h5);
  wire [NUM_DIRECT-1:0] point_mask = (pattern == 3'h5) ? 7'h07 : 7'h7f;
  wire [NUM_DIRECT-1:0] st_rise = st_sync2_reg & ~st_prev_reg & point_mask;
  // A finished point stays blocked until its input is released, so a held level input does not start it again.
  wire [NUM_DIRECT-1:0] st_on   = st_sync2_reg & point_mask & ~held_reg;
  wire [NUM_DIRECT-1:0] st_pick = edge_start ? st_rise : st_on;

  // Direct start inputs and per-point completion.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      moving_reg       <= 1'b0;
      active_point_reg <= 3'h0;
      move_start       <= 1'b0;
      move_point       <= 3'h0;
      move_decel_stop  <= 1'b0;
      move_complete    <= {NUM_DIRECT{1'b0}};
      held_reg         <= {NUM_DIRECT{1'b0}};
    end else begin
      move_start      <= 1'b0;
      move_decel_stop <= 1'b0;
      held_reg        <= held_reg & st_sync2_reg;
      if (~direct_mode) begin
        moving_reg    <= 1'b0;
        move_complete <= {NUM_DIRECT{1'b0}};
        held_reg      <= {NUM_DIRECT{1'b0}};
      end else if (~moving_reg) begin
        if (st_pick != {NUM_DIRECT{1'b0}}) begin
          moving_reg       <= 1'b1;
          active_point_reg <= lowest_set(st_pick);
          move_point       <= lowest_set(st_pick);
          move_start       <= 1'b1;
          move_complete    <= {NUM_DIRECT{1'b0}};
        end else if (pattern == 3'h5) begin
          move_complete <= point_in_band & point_mask;
        end
      end else begin
        if (move_finished) begin
          moving_reg <= 1'b0;
          move_complete <= {{(NUM_DIRECT-1){1'b0}}, 1'b1} << active_point_reg;
          held_reg      <= {{(NUM_DIRECT-1){1'b0}}, 1'b1} << active_point_reg;
        end else if (~edge_start & ~st_sync2_reg[active_point_reg]) begin
          move_decel_stop <= 1'b1;
        end
      end
    end
  end

endmodule

// File: positioner_pio_mode_control_props.sv
// Port-level assertions for the positioner mode control.
module positioner_pio_mode_control_props #(
  parameter NUM_DIRECT = 7
) (
  input logic                  clk,
  input logic                  rst,
  input logic                  mech_end_hit,
  input logic                  home_pos_hit,
  input logic                  home_drive_run,
  input logic                  home_drive_reverse,
  input logic                  home_done,
  input logic                  home_error,
  input logic                  alarm_out,
  input logic                  push_active,
  input logic                  load_out,
  input logic signed [31:0]    shown_position,
  input logic                  push_permitted,
  input logic                  default_band_sel,
  input logic [9:0]            point_count,
  input logic [1:0]            zone_count,
  input logic                  zone_param_used,
  input logic                  teach_jog_allowed,
  input logic [NUM_DIRECT-1:0] move_complete
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence end_leg;
    home_drive_run && !home_drive_reverse && mech_end_hit;
  endsequence
  sequence home_leg;
    home_drive_reverse && home_pos_hit;
  endsequence
  sequence verdict;
    !home_drive_run ##1 (home_done != home_error);
  endsequence
  leg_reverse_a: assert property (end_leg |=> home_drive_reverse)
    else $error("reverse leg missing after end stop");
  home_verdict_a: assert property (home_leg |=> verdict)
    else $error("homing stop or verdict wrong");
  alarm_error_a: assert property (alarm_out == home_error)
    else $error("alarm differs from home error");
  load_clear_a: assert property (!push_active [*3] |-> !load_out)
    else $error("load output without push");
  load_cause_a: assert property ($rose(load_out) |-> $past(push_active))
    else $error("load output rose outside push");
  no_zone_a: assert property (point_count == 10'd512 |-> zone_count == 2'd0)
    else $error("zone output in 512 point pattern");
  one_zone_a: assert property (point_count == 10'd256 || teach_jog_allowed |-> zone_count == 2'd1)
    else $error("zone count wrong for single zone pattern");
  param_zone_a: assert property (zone_param_used |-> zone_count == 2'd2 && point_count == 10'd64)
    else $error("parameter zone outside standard pattern");
  three_push_a: assert property (point_count == 10'd3 |-> !push_permitted)
    else $error("push allowed in three point pattern");
  index_push_a: assert property (default_band_sel |-> !push_permitted)
    else $error("push allowed in index mode");
  wrap_range_a: assert property (default_band_sel && $past(default_band_sel) |->
    shown_position >= 0 && shown_position < 36000)
    else $error("index position outside one turn");
  complete_hot_a: assert property (point_count == 10'd7 |-> $onehot0(move_complete))
    else $error("several complete outputs in seven point pattern");
endmodule

bind positioner_pio_mode_control positioner_pio_mode_control_props #(.NUM_DIRECT(NUM_DIRECT)) props_u (.*);

// File: plc_partner.sv
// PLC model driving the direct move inputs and the motion done pulse.
module plc_partner (
  input  logic       clk,
  input  logic       cmd_go,
  input  logic [2:0] cmd_pt,
  input  logic       cmd_drop,
  input  logic       cmd_slow,
  input  logic       move_start,
  input  logic [6:0] move_complete,
  output logic [6:0] direct_move_inputs,
  output logic       move_finished,
  output logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  initial begin
    direct_move_inputs = 7'h00;
    move_finished = 1'b0;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (cmd_go) begin
      busy <= 1'b1;
      direct_move_inputs <= 7'h01 << cmd_pt;
      @(posedge clk iff move_start === 1'b1);
      if (cmd_drop)
        direct_move_inputs <= 7'h00;
      // A slow answer leaves room to see the deceleration pulses.
      repeat (cmd_slow ? 24 : 3) @(posedge clk);
      move_finished <= 1'b1;
      @(posedge clk);
      move_finished <= 1'b0;
      n = 0;
      while (move_complete[cmd_pt] !== 1'b1 && n < 8) begin
        @(posedge clk);
        n++;
      end
      direct_move_inputs <= 7'h00;
      busy <= 1'b0;
    end
  end
endmodule

// File: positioner_pio_mode_control_tb.sv
// Self-checking bench of the positioner mode control with a PLC partner.
module positioner_pio_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, rst, avs_read, avs_write, avs_waitrequest, home_sensor_pin, mech_end_hit;
  logic [3:0]         avs_address;
  logic [31:0]        avs_writedata, avs_readdata, rs, e;
  logic               home_pos_hit, home_drive_run, home_drive_reverse, home_done, home_error, alarm_out;
  logic               push_active, torque_over, torque_in_range, load_out, move_reverse, push_permitted;
  logic signed [31:0] raw_position, target_position, shown_position;
  logic               default_band_sel, zone_param_used, teach_jog_allowed, move_finished, move_start;
  logic [9:0]         point_count;
  logic [1:0]         zone_count;
  logic [6:0]         direct_move_inputs, point_in_band, move_complete;
  logic               move_decel_stop, cmd_go, cmd_drop, cmd_slow, busy;
  logic [2:0]         move_point, cmd_pt;
  logic [31:0]        exp_q[$], msk_q[$];
  int                 mismatches, check_count, cycles, decel_n, p, i;
  int                 pts[6] = '{64, 64, 256, 512, 7, 3};
  int                 zns[4] = '{2, 1, 1, 0};
  positioner_pio_mode_control #(.TICK_CYCLES(10)) dut_u (.*);
  plc_partner plc_u (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Holds the request until waitrequest is seen low, then idles one edge.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk iff avs_waitrequest === 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] w, input logic [31:0] m);
    exp_q.push_back(w & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task home(input logic [31:0] pol, input logic chg, input logic [31:0] w);
    wr(4'h0, pol);
    home_sensor_pin <= 1'b1;
    wr(4'h4, 32'h1);
    @(posedge clk iff home_drive_run === 1'b1);
    tk(2);
    mech_end_hit <= 1'b1;
    @(posedge clk);
    mech_end_hit <= 1'b0;
    @(posedge clk iff home_drive_reverse === 1'b1);
    home_sensor_pin <= !chg;
    tk(4);
    home_pos_hit <= 1'b1;
    @(posedge clk);
    home_pos_hit <= 1'b0;
    tk(3);
    rd(4'h2, w, 32'h0000_001f);
  endtask
  task go(input int pt, input logic drop, input logic slow);
    cmd_pt <= pt[2:0];
    cmd_drop <= drop;
    cmd_slow <= slow;
    decel_n = 0;
    cmd_go <= 1'b1;
    @(posedge clk);
    cmd_go <= 1'b0;
    @(posedge clk iff busy === 1'b0);
    @(posedge clk);
    chk(move_point, pt);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (move_decel_stop === 1'b1)
      decel_n++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      chk(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    rs = 32'hfe8c;
    {rst, avs_read, avs_write, home_sensor_pin, mech_end_hit, home_pos_hit} = 6'h20;
    {push_active, torque_over, torque_in_range, cmd_go, cmd_drop, cmd_slow} = 6'h00;
    {avs_address, avs_writedata, raw_position, target_position} = 100'h0;
    {point_in_band, cmd_pt} = 10'h0;
    tk(5);
    rst <= 1'b0;
    tk(1);
    rd(4'h0, 32'h0, 32'hffff_ffff);
    rd(4'h1, 32'hff, 32'hffff_ffff);
    rd(4'hf, 32'h0, 32'hffff_ffff);
    chk(point_count, 64);
    for (i = 0; i < 4; i++) begin
      e = rnd();
      wr(4'h0, e);
      rd(4'h0, e, 32'h0000_0f7f);
      rd(4'h2, {e[6], 7'h0}, 32'h80);
    end
    for (i = 0; i < 6; i++) begin
      wr(4'h0, i << 8);
      tk(2);
      chk(point_count, pts[i]);
      if (i < 4)
        chk(zone_count, zns[i]);
      chk(zone_param_used, i == 0);
      chk(teach_jog_allowed, i == 1);
      chk(push_permitted, i != 5);
    end
    $display("register and pattern tests done");
    home(32'h0, 1'b0, 32'h2);
    home(32'h1, 1'b1, 32'h2);
    home(32'h1, 1'b0, 32'h1c);
    home(32'h2, 1'b1, 32'h12);
    home(32'h2, 1'b0, 32'hc);
    $display("homing test done");
    wr(4'h0, 32'h0);
    wr(4'h1, 32'h3);
    push_active <= 1'b1;
    torque_over <= 1'b1;
    tk(60);
    chk(load_out, 0);
    torque_in_range <= 1'b1;
    tk(15);
    chk(load_out, 0);
    tk(25);
    chk(load_out, 1);
    rd(4'h2, 32'h20, 32'h20);
    push_active <= 1'b0;
    torque_in_range <= 1'b0;
    wr(4'h0, 32'h4);
    push_active <= 1'b1;
    tk(45);
    chk(load_out, 1);
    push_active <= 1'b0;
    $display("load test done");
    wr(4'h0, 32'h18);
    tk(3);
    chk(default_band_sel, 1);
    chk(push_permitted, 0);
    for (i = 0; i < 6; i++) begin
      p = rnd();
      raw_position <= p;
      tk(3);
      e = p % 36000 + (p % 36000 < 0 ? 36000 : 0);
      chk(shown_position, e);
    end
    raw_position <= 0;
    target_position <= 27000;
    wr(4'h0, 32'h38);
    tk(3);
    chk(move_reverse, 1);
    wr(4'h0, 32'h28);
    tk(3);
    chk(move_reverse, 0);
    wr(4'h0, 32'h18);
    tk(3);
    chk(move_reverse, 0);
    wr(4'h0, 32'h0);
    raw_position <= 40000;
    tk(3);
    chk(shown_position, 40000);
    $display("axis test done");
    wr(4'h0, 32'h400);
    p = rnd() % 7;
    go(p, 1'b0, 1'b0);
    chk(move_complete, 1 << p);
    chk(decel_n, 0);
    go(p, 1'b1, 1'b1);
    chk(decel_n > 0, 1);
    wr(4'h0, 32'hc00);
    go(6, 1'b1, 1'b1);
    chk(move_complete, 7'h40);
    chk(decel_n, 0);
    wr(4'h0, 32'h500);
    point_in_band <= 7'h05;
    tk(5);
    chk(move_complete, 7'h05);
    $display("direct input test done");
    give_verdict();
  end
endmodule
